//--- sim/dsm_monitor_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dsm_monitor_sva #(
    parameter PCT_W = 16
) (
    input wire logic clk_i,                           // System clock
    input wire logic rst_i,                           // Synchronous reset
    input wire logic oc_one_on_i,                     // Open collector one
    input wire logic oc_two_on_i,                     // Open collector two
    input wire logic relay_on_i,                      // Relay logical state
    input wire logic run_cmd_i,                       // Run command
    input wire logic reverse_cmd_i,                   // Reverse command
    input wire logic [4:0] multi_cmd_i,               // Multi commands
    input wire logic [15:0] term_func_i,              // Terminal functions
    input wire logic [PCT_W-1:0] pid_setpoint_i,      // Setpoint in
    input wire logic tune_start_i,                    // Tune start
    input wire logic tune_step_i,                     // Tune step
    input wire logic tune_done_i,                     // Tune done
    input wire logic tune_abort_i,                    // Tune abort
    input wire logic [19:0] output_terminal_monitor_o,   // Segments
    input wire logic [19:0] operation_status_monitor_o,  // Segments
    input wire logic [19:0] command_status_monitor_o,    // Segments
    input wire logic [19:0] terminal_function_monitor_o, // Segments
    input wire logic [PCT_W-1:0] pid_setpoint_monitor_o, // Setpoint shown
    input wire logic [2:0] autotune_progress_monitor_o   // Progress code
);
    // ----------------------------------------
    // Segment and progress relations
    // ----------------------------------------
    // Edges right after reset still hold reset values, hence the $past(rst_i) guards
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    out_term_a: assert property (!$past(rst_i) |-> output_terminal_monitor_o[10:8] ==
        $past({relay_on_i, oc_two_on_i, oc_one_on_i})) else $error("output monitor mismatch");
    ind_lit_a: assert property (!$past(rst_i) |-> operation_status_monitor_o[19:16] == 4'hF
        && command_status_monitor_o[19:16] == 4'hF && terminal_function_monitor_o[19:16] == 4'hF)
        else $error("indicator segments dark");
    cmd_base_a: assert property (!$past(rst_i) |-> command_status_monitor_o[6:0] ==
        $past({multi_cmd_i, reverse_cmd_i, run_cmd_i})) else $error("command segments wrong");
    timer_seg_a: assert property (command_status_monitor_o[7] |-> $past(run_cmd_i)
        && !command_status_monitor_o[8]) else $error("timer segment without run");
    pulse_seg_a: assert property (command_status_monitor_o[8] |-> $past(run_cmd_i))
        else $error("pulse segment without run");
    func_seg_a: assert property (!$past(rst_i) |-> terminal_function_monitor_o[15:0] ==
        $past(term_func_i)) else $error("function segments wrong");
    pid_pass_a: assert property (!$past(rst_i) |-> pid_setpoint_monitor_o ==
        $past(pid_setpoint_i)) else $error("setpoint not shown");
    tune_start_a: assert property (tune_start_i && !tune_done_i && !tune_abort_i
        |=> autotune_progress_monitor_o == 3'h1) else $error("start did not give 1");
    tune_step_a: assert property (tune_step_i && !tune_start_i && !tune_done_i && !tune_abort_i
        && autotune_progress_monitor_o inside {[3'h1:3'h4]} |=>
        autotune_progress_monitor_o == $past(autotune_progress_monitor_o) + 3'h1) else $error("step wrong");
    tune_result_a: assert property (tune_done_i && !tune_abort_i
        && autotune_progress_monitor_o inside {[3'h1:3'h5]} |=> autotune_progress_monitor_o == 3'h6)
        else $error("done did not give 6");
    tune_abort_a: assert property (tune_abort_i && autotune_progress_monitor_o inside {[3'h1:3'h5]}
        |=> autotune_progress_monitor_o == 3'h7) else $error("abort did not give 7");
    cover property (tune_done_i ##1 autotune_progress_monitor_o == 3'h6);
    cover property (tune_abort_i ##1 autotune_progress_monitor_o == 3'h7);
    cover property (command_status_monitor_o[7]);
    cover property (command_status_monitor_o[8]);
endmodule
`default_nettype wire

//--- sim/dsm_monitor_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsm_regs.vh"
module dsm_monitor_test;
    logic clk_i, rst_i, cyc, stb, we, ack, irq;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, q;
    logic [6:0] pins, cmd;
    logic [2:0] outs, tc;
    logic [13:0] opf;
    logic [15:0] tf, sp, pv, mv, sp_m, pv_m, mv_m;
    logic [3:0] ev, sel;
    logic [19:0] m_in, m_out, m_op, m_cmd, m_tf, shown;
    int mismatches, num_checks;
    dsm_monitor u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
        .run_stop_pin_i(pins[0]), .direction_pin_i(pins[1]), .multi_input_pin_i(pins[6:2]),
        .oc_one_on_i(outs[0]), .oc_two_on_i(outs[1]), .relay_on_i(outs[2]),
        .running_i(opf[0]), .reverse_i(opf[1]), .freq_arrival_i(opf[2]), .overload_i(opf[3]),
        .first_freq_detect_i(opf[4]), .second_freq_detect_i(opf[5]), .cur_upper_detect_i(opf[6]),
        .cur_lower_detect_i(opf[7]), .pid_tuning_i(opf[8]), .timer_op_i(opf[9]),
        .motor_tuning_i(opf[10]), .abnormal_i(opf[11]), .speed_search_i(opf[12]),
        .winding_mode_i(opf[13]), .run_cmd_i(cmd[0]), .reverse_cmd_i(cmd[1]), .multi_cmd_i(cmd[6:2]),
        .term_func_i(tf), .pid_setpoint_i(sp), .pid_measured_i(pv), .pid_output_i(mv),
        .tune_start_i(ev[0]), .tune_step_i(ev[1]), .tune_done_i(ev[2]), .tune_abort_i(ev[3]),
        .input_terminal_monitor_o(m_in), .output_terminal_monitor_o(m_out),
        .operation_status_monitor_o(m_op), .command_status_monitor_o(m_cmd),
        .terminal_function_monitor_o(m_tf), .pid_setpoint_monitor_o(sp_m),
        .pid_measured_monitor_o(pv_m), .pid_output_monitor_o(mv_m), .autotune_progress_monitor_o(tc));
    dsm_panel_model u_panel (.clk_i(clk_i), .seg_i(m_op), .shown_o(shown));
    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            num_checks++;
            if (g !== e) begin
                mismatches++;
                $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        begin
            @(posedge clk_i);
            cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
            sel <= 4'hF;
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (ack !== 1'b1 && n < 50);
            if (n >= 50) chk("ack", 32'h1, 32'h0);
            q = rdat;
            cyc <= 1'b0; stb <= 1'b0;
        end
    endtask
    task wt(input int n);
        begin
            repeat (n) @(posedge clk_i);
            #1;
        end
    endtask
    task tp(input logic [3:0] e, input logic [2:0] x);
        begin
            @(posedge clk_i);
            ev <= e;
            @(posedge clk_i);
            ev <= 4'h0;
            #1;
            chk("tune", {29'h0, x}, {29'h0, tc});
        end
    endtask
    task report_and_stop;
        begin
            if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_regs;
        begin
            wb(0, `DSM_CTRL_OFS, 0); chk("ctrl", 32'h0, q);
            wb(0, `DSM_IRQ_MASK_OFS, 0); chk("mask", 32'h0, q);
            wb(1, 8'h40, 32'hFFFF_FFFF); wb(0, 8'h40, 0); chk("unmapped", 32'h0, q);
        end
    endtask
    task t_terms;
        begin
            for (int i = 0; i < 7; i++) begin
                @(posedge clk_i) pins <= 7'h01 << i;
                wt(6); chk("in_term", 32'h0000_0100 << i, {12'h0, m_in});
            end
            for (int i = 0; i < 3; i++) begin
                @(posedge clk_i) outs <= 3'h1 << i;
                wt(1); chk("out_term", 32'h0000_0100 << i, {12'h0, m_out});
            end
        end
    endtask
    task t_op;
        begin
            for (int i = 0; i < 15; i++) begin
                @(posedge clk_i) opf <= (i < 14) ? 14'h1 << i : 14'h0;
                wt(1); chk("op", 32'h000F_0000 | ((i < 14) ? 32'h1 << i : 0), {12'h0, m_op});
            end
            wt(1); chk("panel", 32'h000F_0000, {12'h0, shown});
            chk("irq", 32'h0, {31'h0, irq});
            wb(0, `DSM_OP_STAT_OFS, 0); chk("op_reg", 32'h000F_0000, q);
            wb(0, `DSM_IRQ_STAT_OFS, 0); chk("irq_stat", 32'h3, q);
            wb(1, `DSM_IRQ_STAT_OFS, 32'h3); wb(0, `DSM_IRQ_STAT_OFS, 0); chk("irq_clr", 32'h0, q);
        end
    endtask
    task t_cmd;
        begin
            for (int i = 0; i < 7; i++) begin
                @(posedge clk_i) cmd <= 7'h01 << i;
                wt(1); chk("cmd", 32'h000F_0000 | (32'h1 << i), {12'h0, m_cmd});
            end
            for (int s = 0; s < 8; s++) begin
                wb(1, `DSM_CTRL_OFS, s);
                @(posedge clk_i) cmd <= 7'h01;
                wt(1); chk("cmd_mode", 32'h000F_0001 | ((s == 3 || s == 4) << 7) | ((s == 5 || s == 6) << 8),
                    {12'h0, m_cmd});
            end
            wb(1, `DSM_CTRL_OFS, 3);
            @(posedge clk_i) cmd <= 7'h00;
            wt(1); chk("cmd_norun", 32'h000F_0000, {12'h0, m_cmd});
        end
    endtask
    task t_func_pid;
        begin
            for (int i = 0; i < 16; i++) begin
                @(posedge clk_i) tf <= 16'h1 << i;
                wt(1); chk("func", 32'h000F_0000 | (32'h1 << i), {12'h0, m_tf});
            end
            @(posedge clk_i);
            sp <= 16'h0032; pv <= 16'h0019; mv <= 16'h0064;
            wt(1);
            chk("sp", 32'h32, {16'h0, sp_m}); chk("pv", 32'h19, {16'h0, pv_m});
            chk("mv", 32'h64, {16'h0, mv_m});
            wb(0, `DSM_PID_MV_OFS, 0); chk("mv_reg", 32'h64, q);
        end
    endtask
    task t_tune;
        begin
            wb(1, `DSM_IRQ_MASK_OFS, 32'hC);
            tp(4'h2, 3'h0); tp(4'h1, 3'h1);
            for (int i = 2; i < 6; i++) tp(4'h2, i);
            tp(4'h2, 3'h5); tp(4'h4, 3'h6); chk("irq", 32'h1, {31'h0, irq});
            wb(0, `DSM_TUNE_OFS, 0); chk("tune_reg", 32'h6, q);
            wb(1, `DSM_IRQ_STAT_OFS, 32'h4); wt(1); chk("irq", 32'h0, {31'h0, irq});
            tp(4'h2, 3'h6); wb(1, `DSM_CTRL_OFS, 32'h0000_0100); wt(1);
            chk("tune", 32'h0, {29'h0, tc});
            tp(4'h1, 3'h1); tp(4'h8, 3'h7); chk("irq", 32'h1, {31'h0, irq});
            wb(1, `DSM_IRQ_MASK_OFS, 32'h0); wt(1); chk("irq", 32'h0, {31'h0, irq});
            wb(1, `DSM_IRQ_STAT_OFS, 32'h8); tp(4'h1, 3'h1);
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0; pins = 7'h0;
        outs = 3'h0; opf = 14'h0; cmd = 7'h0; tf = 16'h0; sp = 16'h0; pv = 16'h0; mv = 16'h0; ev = 4'h0;
        sel = 4'h0;
        mismatches = 0; num_checks = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs; t_terms; t_op; t_cmd; t_func_pid; t_tune;
        report_and_stop;
    end
    initial begin
        #3_000_000;
        mismatches++;
        report_and_stop;
    end
endmodule
bind dsm_monitor dsm_monitor_sva #(.PCT_W(PCT_W)) u_sva (.*);
`default_nettype wire

//--- sim/dsm_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsm_panel_model (
    input wire logic clk_i,          // Panel scan clock
    input wire logic [19:0] seg_i,   // Segment pattern from the drive
    output logic [19:0] shown_o      // Segments currently lit
);
    // Latched per scan so a glitch between edges never reaches the LEDs
    always @(posedge clk_i) shown_o <= seg_i;
endmodule
`default_nettype wire

//--- src/dsm_monitor.v
`timescale 1ns/1ps
`default_nettype none
`include "dsm_regs.vh"
module dsm_monitor #(
    parameter PCT_W = 16
) (
    input wire clk_i,                       // 10 MHz system clock
    input wire rst_i,                       // Synchronous reset, active high
    // Wishbone slave
    input wire wb_cyc_i,                    // Bus cycle
    input wire wb_stb_i,                    // Strobe
    input wire wb_we_i,                     // Write enable
    input wire [7:0] wb_adr_i,              // Byte address
    input wire [3:0] wb_sel_i,              // Byte lanes
    input wire [31:0] wb_dat_i,             // Write data
    output wire [31:0] wb_dat_o,            // Read data
    output wire wb_ack_o,                   // Acknowledge
    output wire irq_o,                      // Level interrupt
    // Terminal pins, asynchronous
    input wire run_stop_pin_i,              // Run/stop terminal
    input wire direction_pin_i,             // Forward/reverse terminal
    input wire [4:0] multi_input_pin_i,     // multi_input_one..five
    // Output terminal states
    input wire oc_one_on_i,                 // Open collector one conducts
    input wire oc_two_on_i,                 // Open collector two conducts
    input wire relay_on_i,                  // Relay logically on
    // Operation status flags
    input wire running_i,                   // Running
    input wire reverse_i,                   // Reverse running
    input wire freq_arrival_i,              // Frequency arrival
    input wire overload_i,                  // Overload
    input wire first_freq_detect_i,         // first_frequency_detect_level reached
    input wire second_freq_detect_i,        // second_frequency_detect_level reached
    input wire cur_upper_detect_i,          // Current upper limit
    input wire cur_lower_detect_i,          // Current lower limit
    input wire pid_tuning_i,                // PID autotuning active
    input wire timer_op_i,                  // Timer operation active
    input wire motor_tuning_i,              // Motor-constant tuning active
    input wire abnormal_i,                  // Abnormality present
    input wire speed_search_i,              // Speed search active
    input wire winding_mode_i,              // Winding-mode control active
    // Command flags
    input wire run_cmd_i,                   // Run command present
    input wire reverse_cmd_i,               // Reverse command present
    input wire [4:0] multi_cmd_i,           // Multi input commands one..five
    // Terminal function flags, a..h then a1..h1
    input wire [15:0] term_func_i,          // Active terminal functions
    // PID values in percent
    input wire [PCT_W-1:0] pid_setpoint_i,  // pid_setpoint
    input wire [PCT_W-1:0] pid_measured_i,  // pid_measured_value
    input wire [PCT_W-1:0] pid_output_i,    // pid_output_value
    // Autotune progress events
    input wire tune_start_i,                // Tuning starts, pulse
    input wire tune_step_i,                 // Tuning advances, pulse
    input wire tune_done_i,                 // Tuning completed, pulse
    input wire tune_abort_i,                // Tuning aborted, pulse
    // Display outputs
    output wire [`DSM_SEG_W-1:0] input_terminal_monitor_o,     // Segments
    output wire [`DSM_SEG_W-1:0] output_terminal_monitor_o,    // Segments
    output wire [`DSM_SEG_W-1:0] operation_status_monitor_o,   // Segments
    output wire [`DSM_SEG_W-1:0] command_status_monitor_o,     // Segments
    output wire [`DSM_SEG_W-1:0] terminal_function_monitor_o,  // Segments
    output wire [PCT_W-1:0] pid_setpoint_monitor_o,            // Percent
    output wire [PCT_W-1:0] pid_measured_monitor_o,            // Percent
    output wire [PCT_W-1:0] pid_output_monitor_o,              // Percent
    output wire [2:0] autotune_progress_monitor_o              // Progress code
);
    // ----------------------------------------
    // Pin synchronisation and autotune tracker
    // ----------------------------------------
    wire [6:0] term_sync;
    wire [2:0] tune_code;
    wire tune_clear;

    dsm_pin_sync #(
        .W(7)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({multi_input_pin_i, direction_pin_i, run_stop_pin_i}),
        .sync_o(term_sync)
    );

    dsm_tune_track u_tune (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(tune_start_i),
        .step_i(tune_step_i),
        .done_i(tune_done_i),
        .abort_i(tune_abort_i),
        .clear_i(tune_clear),
        .code_o(tune_code)
    );

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    reg [`DSM_CTRL_SPEED_W-1:0] speed_set_r;
    reg [`DSM_IRQ_W-1:0] irq_stat_r;
    reg [`DSM_IRQ_W-1:0] irq_mask_r;
    reg ack_r;
    reg [31:0] rdat_r;

    // Writes land on the edge that samples ack high, so a held request writes once
    wire bus_req = wb_cyc_i & wb_stb_i;
    wire wr_take = bus_req & wb_we_i & ack_r;
    wire wr_ctrl = wr_take & (wb_adr_i == `DSM_CTRL_OFS);
    wire wr_stat = wr_take & (wb_adr_i == `DSM_IRQ_STAT_OFS) & wb_sel_i[0];
    wire wr_mask = wr_take & (wb_adr_i == `DSM_IRQ_MASK_OFS) & wb_sel_i[0];

    // Clear is a one-shot: writing the bit acknowledges a tuning result
    assign tune_clear = wr_ctrl & wb_sel_i[1] & wb_dat_i[`DSM_CTRL_TCLR_BIT];

    always @(posedge clk_i) begin
        if (rst_i) begin
            speed_set_r <= `DSM_CTRL_RST;
            irq_mask_r <= `DSM_IRQ_RST;
        end else begin
            if (wr_ctrl && wb_sel_i[0]) begin
                speed_set_r <= wb_dat_i[`DSM_CTRL_SPEED_LSB +: `DSM_CTRL_SPEED_W];
            end
            if (wr_mask) begin
                irq_mask_r <= wb_dat_i[`DSM_IRQ_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // Segment patterns
    // ----------------------------------------
    reg [`DSM_SEG_W-1:0] in_seg_r;
    reg [`DSM_SEG_W-1:0] out_seg_r;
    reg [`DSM_SEG_W-1:0] op_seg_r;
    reg [`DSM_SEG_W-1:0] cmd_seg_r;
    reg [`DSM_SEG_W-1:0] func_seg_r;
    reg [PCT_W-1:0] sp_r;
    reg [PCT_W-1:0] pv_r;
    reg [PCT_W-1:0] mv_r;

    wire timer_mode = (speed_set_r == `DSM_SPEED_TIMER_A) | (speed_set_r == `DSM_SPEED_TIMER_B);
    wire pulse_mode = (speed_set_r == `DSM_SPEED_PULSE_A) | (speed_set_r == `DSM_SPEED_PULSE_B);
    wire timer_seg = timer_mode & run_cmd_i;
    wire pulse_seg = pulse_mode & run_cmd_i;
    reg [`DSM_SEG_W-1:0] in_seg_nxt;
    reg [`DSM_SEG_W-1:0] out_seg_nxt;
    reg [`DSM_SEG_W-1:0] op_seg_nxt;
    reg [`DSM_SEG_W-1:0] cmd_seg_nxt;
    reg [`DSM_SEG_W-1:0] func_seg_nxt;

    // Row slots come from the shared layout so every monitor stays aligned
    always @* begin
        in_seg_nxt = {`DSM_SEG_W{1'b0}};
        in_seg_nxt[`DSM_SEG_LO_LSB +: 7] = term_sync;
        out_seg_nxt = {`DSM_SEG_W{1'b0}};
        out_seg_nxt[`DSM_SEG_LO_LSB +: 2] = {oc_two_on_i, oc_one_on_i};
        // Relay uses the logical state so contact polarity has no effect
        out_seg_nxt[`DSM_SEG_LO_LSB + 2] = relay_on_i;
        op_seg_nxt = {`DSM_SEG_W{1'b0}};
        op_seg_nxt[`DSM_SEG_UP_LSB +: 8] = {cur_lower_detect_i, cur_upper_detect_i, second_freq_detect_i,
            first_freq_detect_i, overload_i, freq_arrival_i, reverse_i, running_i};
        op_seg_nxt[`DSM_SEG_LO_LSB +: 6] = {winding_mode_i, speed_search_i, abnormal_i,
            motor_tuning_i, timer_op_i, pid_tuning_i};
        op_seg_nxt[`DSM_SEG_IND_LSB +: 4] = `DSM_SEG_IND_ON;
        cmd_seg_nxt = {`DSM_SEG_W{1'b0}};
        cmd_seg_nxt[`DSM_SEG_UP_LSB +: 7] = {multi_cmd_i, reverse_cmd_i, run_cmd_i};
        cmd_seg_nxt[`DSM_SEG_UP_LSB + 7] = timer_seg;
        cmd_seg_nxt[`DSM_SEG_LO_LSB] = pulse_seg;
        cmd_seg_nxt[`DSM_SEG_IND_LSB +: 4] = `DSM_SEG_IND_ON;
        func_seg_nxt = {`DSM_SEG_W{1'b0}};
        func_seg_nxt[`DSM_SEG_UP_LSB +: 8] = term_func_i[7:0];
        func_seg_nxt[`DSM_SEG_LO_LSB +: 8] = term_func_i[15:8];
        func_seg_nxt[`DSM_SEG_IND_LSB +: 4] = `DSM_SEG_IND_ON;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            in_seg_r <= {`DSM_SEG_W{1'b0}};
            out_seg_r <= {`DSM_SEG_W{1'b0}};
            op_seg_r <= {`DSM_SEG_W{1'b0}};
            cmd_seg_r <= {`DSM_SEG_W{1'b0}};
            func_seg_r <= {`DSM_SEG_W{1'b0}};
            sp_r <= {PCT_W{1'b0}};
            pv_r <= {PCT_W{1'b0}};
            mv_r <= {PCT_W{1'b0}};
        end else begin
            // Patterns refresh every cycle from the live flags
            in_seg_r <= in_seg_nxt;
            out_seg_r <= out_seg_nxt;
            op_seg_r <= op_seg_nxt;
            cmd_seg_r <= cmd_seg_nxt;
            func_seg_r <= func_seg_nxt;
            sp_r <= pid_setpoint_i;
            pv_r <= pid_measured_i;
            mv_r <= pid_output_i;
        end
    end

    // ----------------------------------------
    // Interrupt events
    // ----------------------------------------
    reg abnormal_d_r;
    reg arrival_d_r;
    wire [`DSM_IRQ_W-1:0] irq_evt;

    always @(posedge clk_i) begin
        if (rst_i) begin
            abnormal_d_r <= 1'b0;
            arrival_d_r <= 1'b0;
        end else begin
            abnormal_d_r <= abnormal_i;
            arrival_d_r <= freq_arrival_i;
        end
    end

    assign irq_evt[`DSM_IRQ_FAULT] = abnormal_i & ~abnormal_d_r;
    assign irq_evt[`DSM_IRQ_ARRIVE] = freq_arrival_i & ~arrival_d_r;
    assign irq_evt[`DSM_IRQ_TDONE] = tune_done_i;
    assign irq_evt[`DSM_IRQ_TABORT] = tune_abort_i;

    // A new event in the clearing cycle survives the write-one clear
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= `DSM_IRQ_RST;
        end else if (wr_stat) begin
            irq_stat_r <= (irq_stat_r & ~wb_dat_i[`DSM_IRQ_W-1:0]) | irq_evt;
        end else begin
            irq_stat_r <= irq_stat_r | irq_evt;
        end
    end

    assign irq_o = |(irq_stat_r & irq_mask_r);

    // ----------------------------------------
    // Wishbone read path
    // ----------------------------------------
    // Unmapped offsets read zero and are still acknowledged
    reg [31:0] rd_mux;

    always @* begin
        case (wb_adr_i)
            `DSM_IN_TERM_OFS: rd_mux = {12'h000, in_seg_r};
            `DSM_OUT_TERM_OFS: rd_mux = {12'h000, out_seg_r};
            `DSM_OP_STAT_OFS: rd_mux = {12'h000, op_seg_r};
            `DSM_CMD_STAT_OFS: rd_mux = {12'h000, cmd_seg_r};
            `DSM_TERM_FUNC_OFS: rd_mux = {12'h000, func_seg_r};
            `DSM_PID_SP_OFS: rd_mux = {{(32-PCT_W){1'b0}}, sp_r};
            `DSM_PID_PV_OFS: rd_mux = {{(32-PCT_W){1'b0}}, pv_r};
            `DSM_PID_MV_OFS: rd_mux = {{(32-PCT_W){1'b0}}, mv_r};
            `DSM_TUNE_OFS: rd_mux = {29'h0000_0000, tune_code};
            `DSM_CTRL_OFS: rd_mux = {28'h000_0000, speed_set_r};
            `DSM_IRQ_STAT_OFS: rd_mux = {28'h000_0000, irq_stat_r};
            `DSM_IRQ_MASK_OFS: rd_mux = {28'h000_0000, irq_mask_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // One wait state: ack follows a request by one edge and drops after one cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r <= bus_req & ~ack_r;
            // Read data is latched when the request is taken and stands until the next one
            if (bus_req && !ack_r) begin
                rdat_r <= rd_mux;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // ----------------------------------------
    // Display outputs
    // ----------------------------------------
    assign input_terminal_monitor_o = in_seg_r;
    assign output_terminal_monitor_o = out_seg_r;
    assign operation_status_monitor_o = op_seg_r;
    assign command_status_monitor_o = cmd_seg_r;
    assign terminal_function_monitor_o = func_seg_r;
    assign pid_setpoint_monitor_o = sp_r;
    assign pid_measured_monitor_o = pv_r;
    assign pid_output_monitor_o = mv_r;
    assign autotune_progress_monitor_o = tune_code;
endmodule
`default_nettype wire

//--- src/dsm_pin_sync.v
`timescale 1ns/1ps
`default_nettype none
module dsm_pin_sync #(
    parameter W = 7
) (
    input wire clk_i,          // System clock
    input wire rst_i,          // Synchronous reset
    input wire [W-1:0] pin_i,  // Asynchronous pin levels
    output wire [W-1:0] sync_o // Filtered levels
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    reg [W-1:0] out_r;
    integer k;

    // A bit moves only once the second and third stages agree
    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
            s3_r <= {W{1'b0}};
            out_r <= {W{1'b0}};
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (k = 0; k < W; k = k + 1) begin
                if (s2_r[k] == s3_r[k]) begin
                    out_r[k] <= s3_r[k];
                end
            end
        end
    end

    assign sync_o = out_r;
endmodule
`default_nettype wire

//--- src/dsm_regs.vh
`ifndef DSM_REGS_VH
`define DSM_REGS_VH

// Register byte offsets
`define DSM_IN_TERM_OFS 8'h00
`define DSM_OUT_TERM_OFS 8'h04
`define DSM_OP_STAT_OFS 8'h08
`define DSM_CMD_STAT_OFS 8'h0C
`define DSM_TERM_FUNC_OFS 8'h10
`define DSM_PID_SP_OFS 8'h14
`define DSM_PID_PV_OFS 8'h18
`define DSM_PID_MV_OFS 8'h1C
`define DSM_TUNE_OFS 8'h20
`define DSM_CTRL_OFS 8'h24
`define DSM_IRQ_STAT_OFS 8'h28
`define DSM_IRQ_MASK_OFS 8'h2C

// Segment vector layout: a..h, a1..h1, i..l
`define DSM_SEG_W 20
`define DSM_SEG_UP_LSB 0
`define DSM_SEG_LO_LSB 8
`define DSM_SEG_IND_LSB 16
`define DSM_SEG_IND_ON 4'hF

// Control register fields
`define DSM_CTRL_SPEED_LSB 0
`define DSM_CTRL_SPEED_W 4
`define DSM_CTRL_TCLR_BIT 8
`define DSM_CTRL_RST 4'h0

// Multi-speed function setting values
`define DSM_SPEED_TIMER_A 4'h3
`define DSM_SPEED_TIMER_B 4'h4
`define DSM_SPEED_PULSE_A 4'h5
`define DSM_SPEED_PULSE_B 4'h6

// Interrupt status bits
`define DSM_IRQ_W 4
`define DSM_IRQ_FAULT 0
`define DSM_IRQ_ARRIVE 1
`define DSM_IRQ_TDONE 2
`define DSM_IRQ_TABORT 3
`define DSM_IRQ_RST 4'h0

// Autotune progress codes
`define DSM_TUNE_IDLE 3'h0
`define DSM_TUNE_FIRST 3'h1
`define DSM_TUNE_LAST 3'h5
`define DSM_TUNE_DONE 3'h6
`define DSM_TUNE_ABORT 3'h7

`endif

//--- src/dsm_tune_track.v
`timescale 1ns/1ps
`default_nettype none
`include "dsm_regs.vh"
module dsm_tune_track (
    input wire clk_i,          // System clock
    input wire rst_i,          // Synchronous reset
    input wire start_i,        // Tuning begins, pulse
    input wire step_i,         // Tuning phase advances, pulse
    input wire done_i,         // Measurement completed, pulse
    input wire abort_i,        // Measurement aborted, pulse
    input wire clear_i,        // Result acknowledged, pulse
    output wire [2:0] code_o   // Progress code
);
    reg [2:0] code_r;
    reg [2:0] code_nxt;

    always @* begin
        code_nxt = code_r;
        if (abort_i && code_r != `DSM_TUNE_IDLE && code_r <= `DSM_TUNE_LAST) begin
            code_nxt = `DSM_TUNE_ABORT;
        end else if (done_i && code_r != `DSM_TUNE_IDLE && code_r <= `DSM_TUNE_LAST) begin
            code_nxt = `DSM_TUNE_DONE;
        end else if (start_i) begin
            code_nxt = `DSM_TUNE_FIRST;
        end else if (step_i && code_r != `DSM_TUNE_IDLE && code_r < `DSM_TUNE_LAST) begin
            code_nxt = code_r + 3'h1;
        end else if (clear_i && code_r > `DSM_TUNE_LAST) begin
            code_nxt = `DSM_TUNE_IDLE;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            code_r <= `DSM_TUNE_IDLE;
        end else begin
            code_r <= code_nxt;
        end
    end

    assign code_o = code_r;
endmodule
`default_nettype wire
